/* File: bench/pwmtfp_monitor.sv */
// assertion checker for the pwm timer prescaler top
`timescale 1ns/1ps
module pwmtfp_monitor
  import pwmtfp_pkg::*;
#(
  parameter int N_TMR = NUM_TIMERS,
  parameter int N_CH  = NUM_CHANNELS
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              bus_clk_enable,
  input wire logic              soft_reset,
  input wire logic              fast_oscillator_clock,
  input wire logic              crystal_clock,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [CNT_W-1:0]  timer_count [N_TMR],
  input wire logic [N_TMR-1:0]  timer_tick,
  input wire logic [N_TMR-1:0]  timer_overflow,
  input wire logic [CNT_W-1:0]  pwm_channel_count [N_CH]
);
  // ------------------------------------------------------------------
  // bus and timebase properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire acc;
  assign acc = psel & penable;
  a_ready_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_unmapped_read: assert property (acc && !pwrite && paddr > 12'h024
    |-> pslverr && prdata == 32'h0) else $error("unmapped read accepted");
  a_count_write_err: assert property (acc && pwrite
    && paddr inside {[12'h018:12'h024]} |-> pslverr)
    else $error("count write not refused");
  a_err_access_only: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  a_ovf_at_zero: assert property (timer_overflow[0] |->
    timer_tick[0] && timer_count[0] == '0) else $error("overflow not at 0");
  a_tick_steps: assert property (timer_tick[0] && !timer_overflow[0]
    |-> timer_count[0] == $past(timer_count[0]) + 14'h1)
    else $error("count did not step on tick");
  // source pulses need two cycles to reach the tick output
  a_gate_stops: assert property (!bus_clk_enable [*3]
    |-> timer_tick == '0) else $error("tick while bus clock gated");
  a_soft_clears: assert property (soft_reset |=> timer_count[1] == '0
    && timer_tick == '0) else $error("soft reset left state");
  c_overflow: cover property (timer_overflow[0]);
  c_bus_error: cover property (acc && pslverr);
  c_tick_one: cover property (timer_tick[1]);
endmodule

bind pwmtfp_top pwmtfp_monitor #(.N_TMR(N_TMR), .N_CH(N_CH)) u_mon (
  .clk(clk), .sys_rst(sys_rst), .bus_clk_enable(bus_clk_enable),
  .soft_reset(soft_reset), .fast_oscillator_clock(fast_oscillator_clock),
  .crystal_clock(crystal_clock), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_count(timer_count),
  .timer_tick(timer_tick), .timer_overflow(timer_overflow),
  .pwm_channel_count(pwm_channel_count));

/* File: bench/pwmtfp_tb.sv */
// self-checking bench for the pwm timer prescaler
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench
  import pwmtfp_pkg::*;
;
  logic              clk = 1'h0;
  logic              sys_rst = 1'h1;
  logic              bus_clk_enable = 1'h1;
  logic              soft_reset = 1'h0;
  logic              fosc = 1'h0;
  logic              xtal = 1'h0;
  logic              psel = 1'h0;
  logic              penable = 1'h0;
  logic              pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic [31:0]       q;
  logic              pready;
  logic              pslverr;
  logic              e;
  logic [CNT_W-1:0]  tcnt [NUM_TIMERS];
  logic [CNT_W-1:0]  ccnt [NUM_CHANNELS];
  logic [CNT_W-1:0]  last;
  logic [3:0]        tick;
  logic [3:0]        ovf;
  int                err_count = 0;
  int                checked = 0;
  int                ph = 0;
  int                p;

  pwmtfp_top dut (.clk(clk), .sys_rst(sys_rst),
    .bus_clk_enable(bus_clk_enable), .soft_reset(soft_reset),
    .fast_oscillator_clock(fosc), .crystal_clock(xtal), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_count(tcnt), .timer_tick(tick), .timer_overflow(ovf),
    .pwm_channel_count(ccnt));

  // ------------------------------------------------------------------
  // clock, source pulses and shared tasks
  // ------------------------------------------------------------------
  always #25 clk = ~clk;
  // unequal pulse spacings make each source recognisable by period
  always @(posedge clk) begin
    ph <= ph + 1;
    fosc <= (ph % 3 == 0);
    xtal <= (ph % 5 == 0);
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic to();
    err_count++;
    $display("mismatch wait exp done got timeout");
    summarize();
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) to();
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic [31:0] cfg(input logic [9:0] a,
                                      input logic [7:0] b,
                                      input logic [3:0] r);
    return {7'h00, 1'h1, 2'h0, a, b, r};
  endfunction

  task automatic wtick(input int t, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick[t] !== 1'h1 && n < 3000);
    if (n >= 3000) to();
  endtask

  task automatic period(input int t, output int n);
    wtick(t, n);
    wtick(t, n);
  endtask

  task automatic wovf();
    int n;
    n = 0;
    do begin
      last = tcnt[0];
      @(negedge clk);
      n++;
    end while (ovf[0] !== 1'h1 && n < 3000);
    if (n >= 3000) to();
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_and_errors();
    apb(1'h0, 12'h000, '0);
    `CHK("conf0 reset", 32'h0000_1000, q)
    `CHK("ready", 1'h1, pready)
    apb(1'h0, 12'h010, '0);
    `CHK("clksel reset", 32'h0, q)
    apb(1'h0, 12'h030, '0);
    `CHK("unmapped err", 1'h1, e)
    apb(1'h1, 12'h018, 32'hFFFF_FFFF);
    `CHK("count write err", 1'h1, e)
    apb(1'h0, 12'h002, '0);
    `CHK("misaligned err", 1'h1, e)
  endtask

  task automatic t_sources();
    int exp [3] = '{2, 6, 10};
    apb(1'h1, 12'h010, 32'h1);
    for (int t = 0; t < 4; t++) apb(1'h1, 12'(4 * t), cfg(2, 0, 1));
    apb(1'h1, 12'h004, cfg(3, 0, 1));
    for (int s = 1; s <= 3; s++) begin
      apb(1'h1, 12'h010, 32'(s));
      period(0, p);
      period(0, p);
      `CHK("tick period", exp[s-1], p)
    end
    apb(1'h1, 12'h010, 32'h1);
    period(1, p);
    period(1, p);
    `CHK("timer1 period", 3, p)
  endtask

  task automatic t_fraction();
    int longs;
    int bad;
    int prev;
    longs = 0;
    bad = 0;
    prev = -1;
    apb(1'h1, 12'h000, cfg(2, 8'h40, 1));
    period(0, p);
    period(0, p);
    for (int i = 0; i < 256; i++) begin
      wtick(0, p);
      if (p == 3 && prev >= 0 && i - prev != 4) bad++;
      if (p == 3) prev = i;
      if (p == 3) longs++;
      else if (p != 2) bad++;
    end
    `CHK("long periods", 64, longs)
    `CHK("spread faults", 0, bad)
  endtask

  task automatic t_update();
    apb(1'h1, 12'h000, cfg(2, 0, 2));
    // an overflow may already be in flight as the write lands
    wovf();
    wovf();
    wovf();
    `CHK("wrap from", 14'h0003, last)
    `CHK("wrap to", 14'h0000, tcnt[0])
    apb(1'h1, 12'h000, cfg(5, 0, 2) & ~32'h0100_0000);
    wovf();
    period(0, p);
    `CHK("staged period", 2, p)
    apb(1'h1, 12'h000, cfg(5, 0, 2));
    wovf();
    wovf();
    period(0, p);
    `CHK("applied period", 5, p)
    apb(1'h0, 12'h000, '0);
    `CHK("update cleared", 32'h0000_5002, q)
  endtask

  task automatic t_channel();
    logic [CNT_W-1:0] p0;
    logic [CNT_W-1:0] p1;
    apb(1'h1, 12'h014, 32'h1);
    repeat (3) @(negedge clk);
    for (int i = 0; i < 20; i++) begin
      p0 = tcnt[0];
      p1 = tcnt[1];
      @(negedge clk);
      `CHK("chan0 count", p1, ccnt[0])
      `CHK("chan1 count", p0, ccnt[1])
    end
  endtask

  task automatic t_hold();
    logic [CNT_W-1:0] held;
    apb(1'h1, 12'h00C, 32'h0180_4003);
    repeat (8) @(negedge clk);
    `CHK("held count", 14'h0000, tcnt[3])
    apb(1'h0, 12'h00C, '0);
    `CHK("held update", 32'h0080_4003, q)
    apb(1'h1, 12'h00C, 32'h0000_4003);
    repeat (14) @(negedge clk);
    `CHK("run count", 1'h1, tcnt[3] != '0)
    apb(1'h1, 12'h00C, 32'h0040_4003);
    repeat (2) @(negedge clk);
    held = tcnt[3];
    repeat (16) @(negedge clk);
    `CHK("paused count", held, tcnt[3])
  endtask

  task automatic t_gate_reset();
    @(posedge clk) bus_clk_enable <= 1'h0;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      `CHK("gated tick", 4'h0, tick)
    end
    apb(1'h1, 12'h008, cfg(9, 0, 3));
    @(posedge clk) bus_clk_enable <= 1'h1;
    apb(1'h0, 12'h008, '0);
    `CHK("gated write", 32'h0000_2001, q)
    @(posedge clk) soft_reset <= 1'h1;
    @(posedge clk) soft_reset <= 1'h0;
    apb(1'h0, 12'h000, '0);
    `CHK("soft conf0", 32'h0000_1000, q)
    apb(1'h0, 12'h010, '0);
    `CHK("soft clksel", 32'h0, q)
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    t_reset_and_errors();
    t_sources();
    t_fraction();
    t_update();
    t_channel();
    t_hold();
    t_gate_reset();
    summarize();
  end
endmodule

/* File: logic/pwmtfp_pkg.sv */
// constants and types for the pwm timer fractional prescaler
// ----------------------------------------------------------------------
// Notes on behaviour
// - there are four identical timers, each with its own divider, overflow setting and counter.
// - each pwm channel picks one timer and follows that timer's counter value.
// - one shared source clock is picked by a two-bit field: 1 bus clock, 2 fast oscillator, 3 crystal.
// - each timer divides the shared source into a tick pulse that steps its counter.
// - the divider is A plus B/256, with A in config bits 21:12 and B in bits 11:4.
// - with B zero the divider gives one tick every A source pulses.
// - with B nonzero, B of every 256 ticks last A+1 source pulses and the rest last A.
// - the longer periods are spread evenly among the shorter ones.
// - software writes a new divider, then sets the update bit; it takes effect at the next overflow.
// - hardware clears the update bit itself once the update is taken.
// - the registers run on the bus clock, gated by a system clock enable and cleared by a system reset bit.
// - the timer path supports a resolution of up to 14 bits.
// - each 14-bit counter steps per tick, counts to 2^resolution-1, overflows and restarts at zero.
// ----------------------------------------------------------------------
package pwmtfp_pkg;

  // --------------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------------
  localparam int NUM_TIMERS   = 4;
  localparam int NUM_CHANNELS = 8;
  localparam int CNT_W        = 14;
  localparam int DIV_A_W      = 10;
  localparam int DIV_B_W      = 8;
  localparam int RES_W        = 4;
  localparam int TSEL_W       = 2;
  localparam int ADDR_W       = 12;

  // --------------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONF0  = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CLKSEL = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_CHSEL  = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_COUNT0 = 12'h018;

  // --------------------------------------------------------------------
  // timer config field layout
  // --------------------------------------------------------------------
  localparam int RES_LSB   = 0;
  localparam int DIV_B_LSB = 4;
  localparam int DIV_A_LSB = 12;
  localparam int PAUSE_BIT = 22;
  localparam int CRST_BIT  = 23;
  localparam int UPD_BIT   = 24;

  // --------------------------------------------------------------------
  // reset values and limits
  // --------------------------------------------------------------------
  localparam logic [RES_W-1:0]   RES_RST   = 4'h0;
  localparam logic [RES_W-1:0]   RES_MAX   = 4'hE;
  localparam logic [DIV_A_W-1:0] DIV_A_RST = 10'h001;
  localparam logic [DIV_B_W-1:0] DIV_B_RST = 8'h00;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_BUS,
    SRC_FOSC,
    SRC_XTAL
  } pwmtfp_src_t;

endpackage

/* File: logic/pwmtfp_prescaler.sv */
// fractional A+B/256 prescaler producing a one-cycle tick enable
`timescale 1ns/1ps
module pwmtfp_prescaler
  import pwmtfp_pkg::*;
#(
  parameter int A_W = DIV_A_W,
  parameter int B_W = DIV_B_W
) (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           clear,
  input  wire logic           src_en,
  input  wire logic [A_W-1:0] div_a,
  input  wire logic [B_W-1:0] div_b,
  output logic                tick
);

  // --------------------------------------------------------------------
  // period arithmetic
  // --------------------------------------------------------------------
  logic [A_W:0] src_cnt;
  logic [B_W-1:0] frac_acc;
  logic         long_period;

  wire [B_W:0] frac_sum   = {1'b0, frac_acc} + {1'b0, div_b};
  wire [A_W:0] period     = {1'b0, div_a} + {{A_W{1'b0}}, long_period};
  // a zero divider would tick on every source pulse; treat it as one
  wire [A_W:0] last       = (period == '0) ? {{A_W{1'b0}}, 1'b1} : period;
  wire [A_W:0] cnt_inc    = src_cnt + {{A_W{1'b0}}, 1'b1};
  wire         end_period = src_en && (cnt_inc >= last);

  // --------------------------------------------------------------------
  // counter and phase accumulator
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_cnt     <= '0;
      frac_acc    <= '0;
      long_period <= 1'b0;
      tick        <= 1'b0;
    end else if (clear) begin
      src_cnt     <= '0;
      frac_acc    <= '0;
      long_period <= 1'b0;
      tick        <= 1'b0;
    end else begin
      tick <= end_period;
      if (end_period) begin
        src_cnt     <= '0;
        // carry out of the accumulator marks a long period: B carries
        // per 256 ticks, spaced as evenly as the 8-bit phase allows
        frac_acc    <= frac_sum[B_W-1:0];
        long_period <= frac_sum[B_W];
      end else if (src_en) begin
        src_cnt <= cnt_inc;
      end
    end
  end

endmodule

/* File: logic/pwmtfp_top.sv */
// four-timer clock select, fractional prescale and timebase counters
`timescale 1ns/1ps
module pwmtfp_top
  import pwmtfp_pkg::*;
#(
  parameter int N_TMR = NUM_TIMERS,
  parameter int N_CH  = NUM_CHANNELS
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              bus_clk_enable,
  input  wire logic              soft_reset,
  input  wire logic              fast_oscillator_clock,
  input  wire logic              crystal_clock,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [CNT_W-1:0]       timer_count [N_TMR],
  output logic [N_TMR-1:0]       timer_tick,
  output logic [N_TMR-1:0]       timer_overflow,
  output logic [CNT_W-1:0]       pwm_channel_count [N_CH]
);

  // --------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------
  pwmtfp_src_t        clk_sel;
  logic [TSEL_W-1:0]  chan_sel     [N_CH];
  logic [RES_W-1:0]   conf_res     [N_TMR];
  logic [DIV_A_W-1:0] conf_a       [N_TMR];
  logic [DIV_B_W-1:0] conf_b       [N_TMR];
  logic [N_TMR-1:0]   conf_pause;
  logic [N_TMR-1:0]   conf_crst;
  logic [N_TMR-1:0]   timer_param_update;
  logic [RES_W-1:0]   act_res      [N_TMR];
  logic [DIV_A_W-1:0] act_a        [N_TMR];
  logic [DIV_B_W-1:0] act_b        [N_TMR];
  logic [N_TMR-1:0]   take_upd;
  logic [N_TMR-1:0]   wr_conf;
  logic [31:0]        rd_word;
  logic               rd_hit;

  // --------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------
  // zero wait states: pready is always high, read data is caught in setup
  wire       setup_ph  = psel && !penable;
  wire       access_ph = psel && penable;
  wire       wr_en     = access_ph && pwrite && bus_clk_enable;
  wire [2:0] word_idx  = paddr[4:2];
  wire       in_conf   = (paddr >= OFS_CONF0) && (paddr < OFS_CLKSEL);
  wire       in_count  = (paddr >= OFS_COUNT0) &&
                         (paddr < OFS_COUNT0 + 12'h010);
  wire [ADDR_W-1:0] cnt_rel = paddr - OFS_COUNT0;
  wire [1:0] cnt_idx   = cnt_rel[3:2];
  wire       hit_clk   = (paddr == OFS_CLKSEL);
  wire       hit_chsel = (paddr == OFS_CHSEL);
  wire       aligned   = (paddr[1:0] == 2'b00);
  wire       mapped    = aligned && (in_conf || in_count ||
                                     hit_clk || hit_chsel);
  wire       ro_write  = pwrite && in_count;

  assign pready  = 1'b1;
  assign pslverr = access_ph && (!mapped || ro_write);

  // --------------------------------------------------------------------
  // shared source clock select
  // --------------------------------------------------------------------
  // sources are enables on clk, so the selection never glitches a clock
  wire src_pulse = bus_clk_enable && (
                   (clk_sel == SRC_BUS) ||
                   ((clk_sel == SRC_FOSC) && fast_oscillator_clock) ||
                   ((clk_sel == SRC_XTAL) && crystal_clock));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_sel <= SRC_NONE;
    end else if (soft_reset) begin
      clk_sel <= SRC_NONE;
    end else if (wr_en && hit_clk && aligned) begin
      clk_sel <= pwmtfp_src_t'(pwdata[1:0]);
    end
  end

  // --------------------------------------------------------------------
  // per-timer staging, prescaler and counter
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_TMR; g++) begin : g_tmr
      logic             tick;
      logic [CNT_W-1:0] cnt;
      wire [RES_W-1:0]  res_eff = (act_res[g] > RES_MAX) ?
                                  RES_MAX : act_res[g];
      wire [CNT_W:0]    top_w   = ({{CNT_W{1'b0}}, 1'b1} << res_eff) -
                                  {{CNT_W{1'b0}}, 1'b1};
      wire [CNT_W-1:0]  top     = top_w[CNT_W-1:0];
      wire              step    = tick && !conf_pause[g] &&
                                  !conf_crst[g];
      wire              ovf     = step && (cnt == top);

      assign wr_conf[g]  = wr_en && in_conf && aligned &&
                           (word_idx == 3'(g));
      // a held counter reset also lets staged values in at once
      assign take_upd[g] = timer_param_update[g] &&
                           (ovf || conf_crst[g]);

      pwmtfp_prescaler #(
        .A_W (DIV_A_W),
        .B_W (DIV_B_W)
      ) u_presc (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clear   (soft_reset || conf_crst[g]),
        .src_en  (src_pulse && !conf_pause[g]),
        .div_a   (act_a[g]),
        .div_b   (act_b[g]),
        .tick    (tick)
      );

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          conf_res[g]           <= RES_RST;
          conf_a[g]             <= DIV_A_RST;
          conf_b[g]             <= DIV_B_RST;
          conf_pause[g]         <= 1'b0;
          conf_crst[g]          <= 1'b0;
          timer_param_update[g] <= 1'b0;
        end else if (soft_reset) begin
          conf_res[g]           <= RES_RST;
          conf_a[g]             <= DIV_A_RST;
          conf_b[g]             <= DIV_B_RST;
          conf_pause[g]         <= 1'b0;
          conf_crst[g]          <= 1'b0;
          timer_param_update[g] <= 1'b0;
        end else begin
          if (wr_conf[g]) begin
            conf_res[g]   <= pwdata[RES_LSB +: RES_W];
            conf_b[g]     <= pwdata[DIV_B_LSB +: DIV_B_W];
            conf_a[g]     <= pwdata[DIV_A_LSB +: DIV_A_W];
            conf_pause[g] <= pwdata[PAUSE_BIT];
            conf_crst[g]  <= pwdata[CRST_BIT];
          end
          // a fresh software set wins over the hardware clear
          timer_param_update[g] <= (wr_conf[g] && pwdata[UPD_BIT]) ||
                                   (timer_param_update[g] &&
                                    !take_upd[g]);
        end
      end

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          act_res[g] <= RES_RST;
          act_a[g]   <= DIV_A_RST;
          act_b[g]   <= DIV_B_RST;
        end else if (soft_reset) begin
          act_res[g] <= RES_RST;
          act_a[g]   <= DIV_A_RST;
          act_b[g]   <= DIV_B_RST;
        end else if (take_upd[g]) begin
          act_res[g] <= conf_res[g];
          act_a[g]   <= conf_a[g];
          act_b[g]   <= conf_b[g];
        end
      end

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          cnt                  <= '0;
          timer_overflow[g]    <= 1'b0;
          timer_tick[g]        <= 1'b0;
        end else if (soft_reset || conf_crst[g]) begin
          cnt                  <= '0;
          timer_overflow[g]    <= 1'b0;
          timer_tick[g]        <= 1'b0;
        end else begin
          timer_tick[g]     <= step;
          timer_overflow[g] <= ovf;
          if (ovf) begin
            cnt <= '0;
          end else if (step) begin
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end

      assign timer_count[g] = cnt;
    end
  endgenerate

  // --------------------------------------------------------------------
  // channel timer select
  // --------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < N_CH; c++) begin : g_ch
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          chan_sel[c]          <= '0;
          pwm_channel_count[c] <= '0;
        end else if (soft_reset) begin
          chan_sel[c]          <= '0;
          pwm_channel_count[c] <= '0;
        end else begin
          if (wr_en && hit_chsel && aligned) begin
            chan_sel[c] <= pwdata[c*TSEL_W +: TSEL_W];
          end
          pwm_channel_count[c] <= timer_count[chan_sel[c]];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b0;
    if (in_conf && aligned) begin
      rd_hit = 1'b1;
      for (int i = 0; i < N_TMR; i++) begin
        if (word_idx == 3'(i)) begin
          rd_word[RES_LSB +: RES_W]     = conf_res[i];
          rd_word[DIV_B_LSB +: DIV_B_W] = conf_b[i];
          rd_word[DIV_A_LSB +: DIV_A_W] = conf_a[i];
          rd_word[PAUSE_BIT]            = conf_pause[i];
          rd_word[CRST_BIT]             = conf_crst[i];
          rd_word[UPD_BIT]              = timer_param_update[i];
        end
      end
    end else if (in_count && aligned) begin
      rd_hit                = 1'b1;
      rd_word[CNT_W-1:0]    = timer_count[cnt_idx];
    end else if (hit_clk) begin
      rd_hit                = 1'b1;
      rd_word[1:0]          = clk_sel;
    end else if (hit_chsel) begin
      rd_hit = 1'b1;
      for (int k = 0; k < N_CH; k++) begin
        rd_word[k*TSEL_W +: TSEL_W] = chan_sel[k];
      end
    end
  end

  // read data is latched in setup, so the access phase sees a flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_hit ? rd_word : '0;
    end
  end

endmodule
